// File: hdl/rsr_pkg.sv
// Constants, types and decode helpers for the return-stack instruction group.
//
// Functional notes
// (RULE_01) Discard opcode drops stack top in Q3.
// (RULE_02) Push opcode stores counter plus two in Q2.
// (RULE_03) Relative call pushes return address in Q2.
// (RULE_04) Relative call adds twice signed field in Q4.
// (RULE_05) Software reset opcode resets all state in Q2.
// (RULE_06) Interrupt return pops into program counter in Q4.
// (RULE_07) Interrupt return sets high or low enable.
// (RULE_08) Shadow bit set restores working, status, bank.
// (RULE_09) Shadow bit clear leaves registers and latches alone.
// (RULE_10) Literal return loads literal and pops in Q4.
// (RULE_11) Literal return takes two cycles, flags untouched.
// (RULE_12) Plain return pops, optional shadow restore, two cycles.
// (RULE_13) Decode in Q1; second cycles change nothing.
package rsr_pkg;

  // ****************************************************************
  // Opcode encodings
  // ****************************************************************
  localparam logic [15:0] OPC_DISCARD     = 16'h0006;
  localparam logic [15:0] OPC_PUSH        = 16'h0005;
  localparam logic [15:0] OPC_SOFT_RESET  = 16'h00FF;
  localparam logic [4:0]  OPC_RELCALL_HI  = 5'h1B;    // Bits 15:11 of the relative call.
  localparam logic [14:0] OPC_IRQRET_HI   = 15'h0008; // Bits 15:1 of the interrupt return.
  localparam logic [14:0] OPC_RETURN_HI   = 15'h0009; // Bits 15:1 of the plain return.
  localparam logic [7:0]  OPC_LITRET_HI   = 8'h0C;    // Bits 15:8 of the literal return.
  localparam int          SHADOW_BIT      = 0;
  localparam int          RELCALL_N_W     = 11;

  // ****************************************************************
  // Register map (byte addresses) and field positions
  // ****************************************************************
  localparam logic [7:0]  OFS_INSTR       = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_PC          = 8'h08;
  localparam logic [7:0]  OFS_TOP         = 8'h0C;
  localparam logic [7:0]  OFS_CTX         = 8'h10;
  localparam logic [7:0]  OFS_SHADOW      = 8'h14;
  localparam logic [7:0]  OFS_IRQEN       = 8'h18;
  localparam logic [7:0]  OFS_PCLAT       = 8'h1C;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_CYC2_BIT   = 1;
  localparam int          STAT_SP_LSB     = 8;
  localparam int          IRQEN_HIGH_BIT  = 0;
  localparam int          IRQEN_LOW_BIT   = 1;
  localparam int          IRQEN_SEL_BIT   = 2;
  localparam int          PCLAT_UPPER_LSB = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic        RST_BIT         = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NONE, OP_DISCARD, OP_PUSH, OP_RELCALL, OP_RESET, OP_IRQRET, OP_RETURN, OP_LITRET
  } rsr_op_e;

  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} rsr_phase_e;

  // Working, status and bank-select registers travel together.
  typedef struct packed {
    logic [7:0] bank;
    logic [7:0] status;
    logic [7:0] working;
  } rsr_ctx_s;

  localparam rsr_ctx_s RST_CTX = '{bank: RST_BYTE, status: RST_BYTE, working: RST_BYTE};

  // Maps an instruction word to the operation that this block executes.
  function automatic rsr_op_e rsr_decode(input logic [15:0] word);
    rsr_op_e op;
    op = OP_NONE;
    if (word == OPC_DISCARD) op = OP_DISCARD;
    else if (word == OPC_PUSH) op = OP_PUSH;
    else if (word == OPC_SOFT_RESET) op = OP_RESET;
    else if (word[15:11] == OPC_RELCALL_HI) op = OP_RELCALL;
    else if (word[15:1] == OPC_IRQRET_HI) op = OP_IRQRET;
    else if (word[15:1] == OPC_RETURN_HI) op = OP_RETURN;
    else if (word[15:8] == OPC_LITRET_HI) op = OP_LITRET;
    return op;
  endfunction

  // Tells whether an operation occupies two instruction cycles.
  function automatic logic rsr_two_cycle(input rsr_op_e op);
    return (op == OP_RELCALL) || (op == OP_IRQRET) || (op == OP_RETURN) || (op == OP_LITRET);
  endfunction

endpackage

// File: hdl/rsr_core.sv
// Executes the return-stack, call, return and software-reset instructions behind an APB slave.
`timescale 1ns/1ps
`default_nettype none

module rsr_core #(
  parameter int PC_W        = 21,
  parameter int STACK_DEPTH = 31,
  parameter int SP_W        = 5
) (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Core state seen by the rest of the chip.
  output logic      [PC_W-1:0]    program_counter,
  output logic      [7:0]         working_reg,
  output logic                    high_prio_global_irq_enable,
  output logic                    low_prio_global_irq_enable,
  output logic                    busy,
  output logic                    soft_reset_pulse
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam int CALL_OFS_W = rsr_pkg::RELCALL_N_W;

  rsr_pkg::rsr_phase_e   phase_r;
  logic                  cyc2_r;
  rsr_pkg::rsr_op_e      op_r;
  logic [15:0]           instr_r;
  logic [7:0]            lit_r;
  logic [CALL_OFS_W-1:0] ofs_r;
  logic [PC_W-1:0]       pc_r;
  logic [SP_W-1:0]       sp_r;
  logic [PC_W-1:0]       stack_mem [STACK_DEPTH];
  rsr_pkg::rsr_ctx_s     ctx_r;
  rsr_pkg::rsr_ctx_s     shadow_r;
  logic                  ienh_r;
  logic                  ienl_r;
  logic                  low_sel_r;
  logic [7:0]            pc_high_latch_r;
  logic [7:0]            pc_upper_latch_r;
  logic                  soft_rst_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic [31:0]           prdata_r;

  // ****************************************************************
  // Sequencing terms
  // ****************************************************************

  // Work happens only in the first cycle; the second cycle is idle time.
  wire                   first_cyc   = !cyc2_r;                                   // RULE_13
  wire                   at_q1       = (phase_r == rsr_pkg::PH_Q1) && first_cyc;
  wire                   at_q2       = (phase_r == rsr_pkg::PH_Q2) && first_cyc;
  wire                   at_q3       = (phase_r == rsr_pkg::PH_Q3) && first_cyc;
  wire                   at_q4       = (phase_r == rsr_pkg::PH_Q4) && first_cyc;
  wire                   sw_rst      = at_q2 && (op_r == rsr_pkg::OP_RESET);      // RULE_05
  wire                   do_push     = at_q2 && ((op_r == rsr_pkg::OP_PUSH) ||
                                                 (op_r == rsr_pkg::OP_RELCALL));  // RULE_02 RULE_03
  wire                   do_discard  = at_q3 && (op_r == rsr_pkg::OP_DISCARD);    // RULE_01
  wire                   is_return   = (op_r == rsr_pkg::OP_IRQRET) || (op_r == rsr_pkg::OP_RETURN) ||
                                       (op_r == rsr_pkg::OP_LITRET);
  wire                   do_ret_pop  = at_q4 && is_return;                        // RULE_06 RULE_10 RULE_12
  wire                   do_pop      = do_discard || do_ret_pop;
  wire                   shadow_sel  = instr_r[rsr_pkg::SHADOW_BIT];
  wire                   do_restore  = at_q4 && shadow_sel &&
                                       ((op_r == rsr_pkg::OP_IRQRET) ||
                                        (op_r == rsr_pkg::OP_RETURN));            // RULE_08 RULE_09 RULE_12
  wire                   stack_empty = (sp_r == '0);
  wire                   stack_full  = (sp_r == SP_W'(STACK_DEPTH));
  wire [SP_W-1:0]        top_idx     = sp_r - SP_W'(1);
  wire [PC_W-1:0]        top_value   = stack_empty ? '0 : stack_mem[top_idx];
  wire [PC_W-1:0]        jump_step   = {{(PC_W-CALL_OFS_W-1){ofs_r[CALL_OFS_W-1]}}, ofs_r, 1'b0};
  wire                   idle        = (phase_r == rsr_pkg::PH_IDLE);

  // ****************************************************************
  // APB decode
  // ****************************************************************

  // A transfer is complete on the edge where the registered ready is high.
  wire                   apb_done    = psel && penable && pready_r;
  wire                   hit_instr   = (paddr == rsr_pkg::OFS_INSTR);
  wire                   hit_status  = (paddr == rsr_pkg::OFS_STATUS);
  wire                   hit_pc      = (paddr == rsr_pkg::OFS_PC);
  wire                   hit_top     = (paddr == rsr_pkg::OFS_TOP);
  wire                   hit_ctx     = (paddr == rsr_pkg::OFS_CTX);
  wire                   hit_shadow  = (paddr == rsr_pkg::OFS_SHADOW);
  wire                   hit_irqen   = (paddr == rsr_pkg::OFS_IRQEN);
  wire                   hit_pclat   = (paddr == rsr_pkg::OFS_PCLAT);
  wire                   hit_any     = hit_instr || hit_status || hit_pc || hit_top || hit_ctx ||
                                       hit_shadow || hit_irqen || hit_pclat;
  // State registers may only be written while no instruction is in flight.
  wire                   wr_ok       = pwrite && idle && hit_any && !hit_status &&
                                       !(hit_top && stack_empty);
  wire                   wr_fire     = apb_done && wr_ok;
  wire                   bad_access  = !hit_any || (pwrite && !wr_ok);
  wire                   start       = wr_fire && hit_instr;

  // Read data selection.
  wire [31:0]            status_word = {16'h0000, {(8-SP_W){1'b0}}, sp_r, 6'h00, cyc2_r, !idle};
  wire [31:0]            irqen_word  = {29'h0, low_sel_r, ienl_r, ienh_r};
  wire [31:0]            rd_data     = hit_instr  ? {16'h0000, instr_r} :
                                       hit_status ? status_word :
                                       hit_pc     ? 32'(pc_r) :
                                       hit_top    ? 32'(top_value) :
                                       hit_ctx    ? {8'h00, ctx_r} :
                                       hit_shadow ? {8'h00, shadow_r} :
                                       hit_irqen  ? irqen_word :
                                       hit_pclat  ? {16'h0000, pc_upper_latch_r, pc_high_latch_r} :
                                       32'h0000_0000;

  // ****************************************************************
  // APB slave: one wait state, error on unmapped or refused access
  // ****************************************************************

  // Ready rises at the end of the first access cycle and drops after completion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && bad_access;
      prdata_r  <= (psel && penable && !pready_r && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************

  // Walks Q1 to Q4, repeating once for two-cycle instructions.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= rsr_pkg::PH_IDLE;
      cyc2_r  <= 1'b0;
    end else begin
      unique case (phase_r)
        rsr_pkg::PH_IDLE: begin
          if (start) begin
            phase_r <= rsr_pkg::PH_Q1;
          end
        end
        rsr_pkg::PH_Q1: phase_r <= rsr_pkg::PH_Q2;
        rsr_pkg::PH_Q2: phase_r <= rsr_pkg::PH_Q3;
        rsr_pkg::PH_Q3: phase_r <= rsr_pkg::PH_Q4;
        rsr_pkg::PH_Q4: begin
          if (first_cyc && rsr_pkg::rsr_two_cycle(op_r)) begin // RULE_04 RULE_06 RULE_11 RULE_12
            phase_r <= rsr_pkg::PH_Q1;
            cyc2_r  <= 1'b1;
          end else begin
            phase_r <= rsr_pkg::PH_IDLE;
            cyc2_r  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Instruction latch, decode in Q1 and operand capture in Q2.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_r <= 16'h0000;
      op_r    <= rsr_pkg::OP_NONE;
      lit_r   <= rsr_pkg::RST_BYTE;
      ofs_r   <= '0;
    end else begin
      if (start) begin
        instr_r <= pwdata[15:0];
        op_r    <= rsr_pkg::OP_NONE;
      end
      if (at_q1) begin
        op_r <= rsr_pkg::rsr_decode(instr_r); // RULE_13
      end
      if (at_q2) begin
        lit_r <= instr_r[7:0];                // RULE_10
        ofs_r <= instr_r[CALL_OFS_W-1:0];     // RULE_03
      end
    end
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************

  // Advances at fetch, then jumps or returns in Q4 of the first cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= '0;
    end else if (sw_rst) begin
      pc_r <= '0;                            // RULE_05
    end else if (at_q1) begin
      pc_r <= pc_r + PC_W'(2);               // RULE_02
    end else if (at_q4 && (op_r == rsr_pkg::OP_RELCALL)) begin
      pc_r <= pc_r + jump_step;              // RULE_04
    end else if (do_ret_pop) begin
      pc_r <= top_value;                     // RULE_06 RULE_10 RULE_12
    end else if (wr_fire && hit_pc) begin
      pc_r <= pwdata[PC_W-1:0];
    end
  end

  // ****************************************************************
  // Return stack
  // ****************************************************************

  // Pointer counts live entries; a push when full overwrites the top.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= '0;
    end else if (sw_rst) begin
      sp_r <= '0;                            // RULE_05
    end else if (do_push && !stack_full) begin
      sp_r <= sp_r + SP_W'(1);               // RULE_02 RULE_03
    end else if (do_pop && !stack_empty) begin
      sp_r <= top_idx;                       // RULE_01 RULE_06
    end
  end

  // Entry storage; the program counter here already holds the return address.
  always_ff @(posedge pclk) begin
    if (do_push) begin
      stack_mem[stack_full ? top_idx : sp_r] <= pc_r; // RULE_02 RULE_03
    end else if (wr_fire && hit_top) begin
      stack_mem[top_idx] <= pwdata[PC_W-1:0];
    end
  end

  // ****************************************************************
  // Working, status, bank and shadows
  // ****************************************************************

  // Restores from shadow or loads the literal in Q4.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_r <= rsr_pkg::RST_CTX;
    end else if (sw_rst) begin
      ctx_r <= rsr_pkg::RST_CTX;             // RULE_05
    end else if (do_restore) begin
      ctx_r <= shadow_r;                     // RULE_08 RULE_12
    end else if (at_q4 && (op_r == rsr_pkg::OP_LITRET)) begin
      ctx_r.working <= lit_r;                // RULE_10 RULE_11
    end else if (wr_fire && hit_ctx) begin
      ctx_r <= pwdata[23:0];
    end
  end

  // Shadow copies are loaded only by software here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_r <= rsr_pkg::RST_CTX;
    end else if (sw_rst) begin
      shadow_r <= rsr_pkg::RST_CTX;          // RULE_05
    end else if (wr_fire && hit_shadow) begin
      shadow_r <= pwdata[23:0];
    end
  end

  // Address latches are never touched by the returns.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_high_latch_r  <= rsr_pkg::RST_BYTE;
      pc_upper_latch_r <= rsr_pkg::RST_BYTE;
    end else if (sw_rst) begin
      pc_high_latch_r  <= rsr_pkg::RST_BYTE; // RULE_05
      pc_upper_latch_r <= rsr_pkg::RST_BYTE;
    end else if (wr_fire && hit_pclat) begin
      pc_high_latch_r  <= pwdata[7:0];
      pc_upper_latch_r <= pwdata[rsr_pkg::PCLAT_UPPER_LSB +: 8];
    end
  end

  // ****************************************************************
  // Interrupt enables
  // ****************************************************************

  // The interrupt return sets the enable that the select bit names.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ienh_r    <= rsr_pkg::RST_BIT;
      ienl_r    <= rsr_pkg::RST_BIT;
      low_sel_r <= rsr_pkg::RST_BIT;
    end else if (sw_rst) begin
      ienh_r    <= rsr_pkg::RST_BIT;         // RULE_05
      ienl_r    <= rsr_pkg::RST_BIT;
      low_sel_r <= rsr_pkg::RST_BIT;
    end else if (at_q4 && (op_r == rsr_pkg::OP_IRQRET)) begin
      ienh_r <= ienh_r | !low_sel_r;         // RULE_07
      ienl_r <= ienl_r | low_sel_r;          // RULE_07
    end else if (wr_fire && hit_irqen) begin
      ienh_r    <= pwdata[rsr_pkg::IRQEN_HIGH_BIT];
      ienl_r    <= pwdata[rsr_pkg::IRQEN_LOW_BIT];
      low_sel_r <= pwdata[rsr_pkg::IRQEN_SEL_BIT];
    end
  end

  // Flags the software reset to the rest of the chip for one clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= sw_rst;                  // RULE_05
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Every output is a flip-flop.
  assign prdata                      = prdata_r;
  assign pready                      = pready_r;
  assign pslverr                     = pslverr_r;
  assign program_counter             = pc_r;
  assign working_reg                 = ctx_r.working;
  assign high_prio_global_irq_enable = ienh_r;
  assign low_prio_global_irq_enable  = ienl_r;
  assign soft_reset_pulse            = soft_rst_r;

  // Busy mirrors the registered phase.
  logic busy_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= !((phase_r == rsr_pkg::PH_IDLE) && !start) &&
                !((phase_r == rsr_pkg::PH_Q4) && !(first_cyc && rsr_pkg::rsr_two_cycle(op_r)));
    end
  end
  assign busy = busy_r;

endmodule // rsr_core

`default_nettype wire

// File: bench/rsr_core_assertions.sv
// Port-level checks for the return-stack instruction block.
`timescale 1ns/1ps
`default_nettype none
module rsr_core_assertions #(
  parameter int PC_W = 21
) (
  // Clock and reset.
  input wire logic            pclk,
  input wire logic            presetn,
  // APB side.
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // Core state.
  input wire logic [PC_W-1:0] program_counter,
  input wire logic [7:0]      working_reg,
  input wire logic            high_prio_global_irq_enable,
  input wire logic            low_prio_global_irq_enable,
  input wire logic            busy,
  input wire logic            soft_reset_pulse
);
  // A completed write is the only way besides execution to move state.
  wire apb_wr = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus handshake: one wait state, one-cycle answer.
  ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("late pready");
  ready_one_a: assert property (pready |=> !pready) else $error("pready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  rdata_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  // Execution timing and side effects.
  q1_step_a: assert property ($rose(busy) |=> program_counter == PC_W'($past(program_counter) + 2))
    else $error("no step in first phase");
  busy_span_a: assert property ($rose(busy) |-> busy[*4] ##1 (!busy or busy[*4] ##1 !busy))
    else $error("bad run length");
  pc_quiet_a: assert property ($changed(program_counter) |-> $past(busy) || $past(apb_wr))
    else $error("counter moved while idle");
  w_quiet_a: assert property ($changed(working_reg) |-> $past(busy) || $past(apb_wr))
    else $error("working moved while idle");
  irq_set_a: assert property ($rose(high_prio_global_irq_enable) || $rose(low_prio_global_irq_enable)
    |-> $past(busy) || $past(apb_wr)) else $error("enable rose while idle");
  rst_clear_a: assert property (soft_reset_pulse |-> program_counter == '0 && working_reg == 8'h0
    && !high_prio_global_irq_enable && !low_prio_global_irq_enable) else $error("state not cleared");
  rst_time_a: assert property (soft_reset_pulse |-> $past(busy, 2) && !$past(busy, 3))
    else $error("reset pulse mistimed");
  // Main scenarios reached.
  soft_reset_c: cover property (soft_reset_pulse);
  refused_c: cover property (pslverr);
  low_irq_c: cover property ($rose(low_prio_global_irq_enable));
endmodule // rsr_core_assertions
bind rsr_core rsr_core_assertions #(.PC_W(PC_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .program_counter, .working_reg, .high_prio_global_irq_enable,
  .low_prio_global_irq_enable, .busy, .soft_reset_pulse);
`default_nettype wire

// File: bench/rsr_fetch_model.sv
// Fetch-path model: the APB master that hands instruction words in and reads state back.
`timescale 1ns/1ps
`default_nettype none
module rsr_fetch_model (
  // Clock.
  input  wire logic        pclk,
  // APB master side.
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // The bus rests idle until the first request.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer; the request stands until pready is seen high at a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // rsr_fetch_model
`default_nettype wire

// File: bench/rsr_core_tb.sv
// Self-checking bench for the return-stack instruction block.
`timescale 1ns/1ps
`default_nettype none
module rsr_core_tb;
  localparam int PC_W = 21;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, rde;
  logic            high_prio_global_irq_enable, low_prio_global_irq_enable, soft_reset_pulse;
  logic [7:0]      paddr, working_reg;
  logic [31:0]     pwdata, prdata, rdv;
  logic [PC_W-1:0] program_counter;
  int              n_errors = 0;
  int              cmp_count = 0;
  // Free-running clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  rsr_core #(.PC_W(PC_W)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .program_counter, .working_reg, .high_prio_global_irq_enable,
    .low_prio_global_irq_enable, .busy, .soft_reset_pulse);
  rsr_fetch_model fm (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // Comparison, bus and execution helpers.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    fm.xfer(1'b1, a, d, rdv, rde);
    check({31'h0, rde}, {31'h0, ee});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    fm.xfer(1'b0, a, 32'h0, rdv, rde);
    check(rdv, exp);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      fm.xfer(1'b0, rsr_pkg::OFS_STATUS, 32'h0, rdv, rde);
      n++;
    end while (rdv[0] !== 1'b0 && n < 20);
    if (rdv[0] !== 1'b0) n_errors++;
  endtask
  task automatic run(input logic [15:0] op);
    wr(rsr_pkg::OFS_INSTR, {16'h0, op}, 1'b0);
    idle();
  endtask
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    summarize();
  end
  // Test sequence.
  initial begin
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(rsr_pkg::OFS_STATUS, 32'h0);
    wr(rsr_pkg::OFS_PC, 32'h100, 1'b0);
    wr(rsr_pkg::OFS_PCLAT, 32'h1234, 1'b0);
    run(16'h0005);
    rd(rsr_pkg::OFS_TOP, 32'h102);
    run(16'h0005);
    rd(rsr_pkg::OFS_STATUS, 32'h200);
    run(16'h0006);
    rd(rsr_pkg::OFS_TOP, 32'h102);
    rd(rsr_pkg::OFS_PC, 32'h106);
    $display("test push_discard done");
    run(16'hDFFF);
    rd(rsr_pkg::OFS_TOP, 32'h108);
    rd(rsr_pkg::OFS_PC, 32'h106);
    run(16'hDBFF);
    rd(rsr_pkg::OFS_PC, 32'h906);
    run(16'h0C5A);
    rd(rsr_pkg::OFS_PC, 32'h108);
    rd(rsr_pkg::OFS_CTX, 32'h5A);
    check({24'h0, working_reg}, 32'h5A);
    check(32'(program_counter), 32'h108);
    rd(rsr_pkg::OFS_PCLAT, 32'h1234);
    rd(rsr_pkg::OFS_STATUS, 32'h200);
    $display("test call_literal done");
    wr(rsr_pkg::OFS_SHADOW, 32'h30201, 1'b0);
    run(16'h0011);
    rd(rsr_pkg::OFS_CTX, 32'h30201);
    rd(rsr_pkg::OFS_IRQEN, 32'h1);
    rd(rsr_pkg::OFS_PC, 32'h108);
    wr(rsr_pkg::OFS_IRQEN, 32'h4, 1'b0);
    wr(rsr_pkg::OFS_SHADOW, 32'hA0B0C, 1'b0);
    run(16'h0010);
    rd(rsr_pkg::OFS_CTX, 32'h30201);
    rd(rsr_pkg::OFS_IRQEN, 32'h6);
    rd(rsr_pkg::OFS_PCLAT, 32'h1234);
    rd(rsr_pkg::OFS_PC, 32'h102);
    run(16'h0005);
    run(16'h0013);
    rd(rsr_pkg::OFS_PC, 32'h104);
    rd(rsr_pkg::OFS_CTX, 32'hA0B0C);
    run(16'h0005);
    run(16'h0012);
    rd(rsr_pkg::OFS_PC, 32'h106);
    $display("test returns done");
    wr(rsr_pkg::OFS_INSTR, 32'h5, 1'b0);
    wr(rsr_pkg::OFS_PC, 32'h55, 1'b1);
    idle();
    rd(rsr_pkg::OFS_PC, 32'h108);
    wr(rsr_pkg::OFS_STATUS, 32'h0, 1'b1);
    fm.xfer(1'b0, 8'h20, 32'h0, rdv, rde);
    check(rdv, 32'h0);
    check({31'h0, rde}, 32'h1);
    $display("test refusals done");
    run(16'h00FF);
    rd(rsr_pkg::OFS_PC, 32'h0);
    rd(rsr_pkg::OFS_CTX, 32'h0);
    rd(rsr_pkg::OFS_PCLAT, 32'h0);
    rd(rsr_pkg::OFS_STATUS, 32'h0);
    check({30'h0, high_prio_global_irq_enable, low_prio_global_irq_enable}, 32'h0);
    $display("test soft_reset done");
    summarize();
  end
endmodule // rsr_core_tb
`default_nettype wire
